/* design/mrs_pkg.sv */
// Constants, types and register map of the motor ramp and stop sequencer.
package mrs_pkg;
	localparam int CLK_HZ   = 50_000_000;
	localparam int TICK_US  = 1000;
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int TICKS_PER_RAMP_UNIT = 100;
	localparam int TICKS_PER_BRK_UNIT  = 10;
	localparam int N_CFG = 13;
	localparam logic [3:0] IDX_STAT0 = 4'hd;
	localparam logic [3:0] IDX_STAT1 = 4'he;
	localparam logic [31:0] RST_CTRL  = 32'h0000_0001;
	localparam logic [31:0] RST_TGT   = 32'h0000_0000;
	localparam logic [31:0] RST_TUP   = 32'h0000_0032;
	localparam logic [31:0] RST_TDN   = 32'h0000_0064;
	localparam logic [31:0] RST_MAXF  = 32'h0000_1770;
	localparam logic [31:0] RST_BASEF = 32'h0000_1770;
	localparam logic [31:0] RST_STF   = 32'h0000_0032;
	localparam logic [31:0] RST_VSC   = 32'h0000_0064;
	localparam logic [31:0] RST_BOOST = 32'h0004_0505;
	localparam logic [31:0] RST_SBRK  = 32'h0000_0032;
	localparam logic [31:0] RST_DBRK  = 32'h0000_6432;
	localparam logic [31:0] RST_DBF   = 32'h000a_01f4;
	localparam logic [31:0] RST_TFN   = 32'h0110_8820;
	localparam logic [31:0] RAMP_HI  = 32'd60000;
	localparam logic [31:0] FREQ_HI  = 32'd20000;
	localparam logic [31:0] BASE_LO  = 32'd3000;
	localparam logic [31:0] STF_LO   = 32'd10;
	localparam logic [31:0] STF_HI   = 32'd1000;
	localparam logic [31:0] VSC_LO   = 32'd40;
	localparam logic [31:0] VSC_HI   = 32'd110;
	localparam logic [31:0] BOOST_HI = 32'd15;
	localparam logic [31:0] BLVL_HI  = 32'd200;
	localparam logic [31:0] BTIM_HI  = 32'd6000;
	localparam logic [4:0] FN_FX   = 5'h00;
	localparam logic [4:0] FN_RX   = 5'h01;
	localparam logic [4:0] FN_HOLD = 5'h17;
	localparam logic [1:0] STOP_DEC   = 2'h0;
	localparam logic [1:0] STOP_DCB   = 2'h1;
	localparam logic [1:0] STOP_COAST = 2'h2;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	localparam int SEG_SH = 6;
	localparam logic [10:0] V_UNITY = 11'h400;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SBRK = 5'b00010,
		ST_RAMP = 5'b00100,
		ST_WAIT = 5'b01000,
		ST_DCB  = 5'b10000
	} mrs_state_t;
	typedef struct packed {
		logic [15:0] freq;
		logic [10:0] volt;
		logic        dcb_on;
		logic [7:0]  dcb_lvl;
	} mrs_drive_t;
endpackage : mrs_pkg

/* design/mrs_sequencer.sv */
// Ramp, voltage curve and stop sequencer with its AXI4-Lite register file.
`timescale 1ns/1ps
module mrs_sequencer
	import mrs_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	output logic [1:0]       S_AXI_BRESP,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	input  wire logic        RUN_KEY,
	input  wire logic [4:0]  TERM,
	input  wire logic        DIR_REV,
	input  wire logic        FAULT,
	output mrs_drive_t       DRIVE,
	output logic             RUNNING
);
	function automatic logic [31:0] lim(input logic [31:0] v,
		input logic [31:0] lo, input logic [31:0] hi);
		lim = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : lim

	function automatic logic fn_hit(input logic [24:0] fn,
		input logic [4:0] t, input logic [4:0] code);
		fn_hit = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (t[i] && fn[i*5 +: 5] == code)
				fn_hit = 1'b1;
		end
	endfunction : fn_hit

	function automatic logic [31:0] rstv(input int i);
		unique case (i)
			0: rstv = RST_CTRL;
			1: rstv = RST_TGT;
			2: rstv = RST_TUP;
			3: rstv = RST_TDN;
			4: rstv = RST_MAXF;
			5: rstv = RST_BASEF;
			6: rstv = RST_STF;
			7: rstv = RST_VSC;
			8: rstv = RST_BOOST;
			9: rstv = RST_SBRK;
			10: rstv = RST_DBRK;
			11: rstv = RST_DBF;
			default: rstv = RST_TFN;
		endcase
	endfunction : rstv

	function automatic logic [31:0] clampw(input logic [3:0] i,
		input logic [31:0] d, input logic [31:0] mx);
		unique case (i)
			4'h0: clampw = {24'h0, d[7:0]};
			4'h1: clampw = lim({16'h0, d[15:0]}, 32'h0, mx);
			4'h2, 4'h3: clampw = lim({16'h0, d[15:0]}, 32'h0, RAMP_HI);
			4'h4: clampw = lim({16'h0, d[15:0]}, 32'h0, FREQ_HI);
			4'h5: clampw = lim({16'h0, d[15:0]}, BASE_LO, FREQ_HI);
			4'h6: clampw = lim({16'h0, d[15:0]}, STF_LO, STF_HI);
			4'h7: clampw = lim({24'h0, d[7:0]}, VSC_LO, VSC_HI);
			4'h8: clampw = {8'h0, d[23:16],
				8'(lim({24'h0, d[15:8]}, 32'h0, BOOST_HI)),
				8'(lim({24'h0, d[7:0]}, 32'h0, BOOST_HI))};
			4'h9, 4'ha: clampw = {8'h0,
				16'(lim({16'h0, d[23:8]}, 32'h0, BTIM_HI)),
				8'(lim({24'h0, d[7:0]}, 32'h0, BLVL_HI))};
			4'hb: clampw = {16'(lim({16'h0, d[31:16]}, 32'h0, BTIM_HI)),
				16'(lim({16'h0, d[15:0]}, 32'h0, BTIM_HI))};
			default: clampw = {7'h0, d[24:0]};
		endcase
	endfunction : clampw

	logic [31:0] cfg_ff [0:N_CFG-1];
	logic [15:0] tdiv_ff;
	logic        aw_ff, w_ff, bv_ff, rv_ff;
	logic [7:0]  awa_ff;
	logic [31:0] wd_ff, rd_ff;
	logic [3:0]  ws_ff;
	logic [1:0]  br_ff, rr_ff;
	mrs_state_t  st_ff, nxt_st;
	logic [15:0] freq_ff, nxt_freq, orig_ff;
	logic [24:0] acc_ff, nxt_acc;
	logic [23:0] tim_ff, nxt_tim;
	logic [10:0] volt_ff, nxt_volt, r_ff;
	logic        dcb_ff, fault_ff, lock_ff;
	logic [7:0]  lvl_ff;
	logic [16:0] rem_ff;
	logic [25:0] quo_ff;
	logic [4:0]  cnt_ff;
	logic [31:0] rsel;

	wire tick = tdiv_ff == 16'(TICK_CYCLES - 1);
	always_ff @(posedge CLK) begin
		if (!RESETN || tick)
			tdiv_ff <= 16'h0;
		else
			tdiv_ff <= tdiv_ff + 16'h1;
	end

	wire [31:0] ctrl  = cfg_ff[0];
	wire        term_mode = ctrl[0];
	wire        restart_en = ctrl[1];
	wire [1:0]  stop_m = ctrl[3:2];
	wire        s_up = ctrl[4];
	wire        s_dn = ctrl[5];
	wire        vf_sq = ctrl[6];
	wire        boost_auto = ctrl[7];
	wire [15:0] tgt   = cfg_ff[1][15:0];
	wire [15:0] tup   = cfg_ff[2][15:0];
	wire [15:0] tdn   = cfg_ff[3][15:0];
	wire [15:0] maxf  = cfg_ff[4][15:0];
	wire [15:0] basef = cfg_ff[5][15:0];
	wire [15:0] stf   = cfg_ff[6][15:0];
	wire [7:0]  vsc   = cfg_ff[7][7:0];
	wire [31:0] bst   = cfg_ff[8];
	wire [7:0]  sb_lvl = cfg_ff[9][7:0];
	wire [15:0] sb_t  = cfg_ff[9][23:8];
	wire [7:0]  db_lvl = cfg_ff[10][7:0];
	wire [15:0] db_t  = cfg_ff[10][23:8];
	wire [15:0] dbf   = cfg_ff[11][15:0];
	wire [15:0] db_w  = cfg_ff[11][31:16];
	wire [24:0] tfn   = cfg_ff[12][24:0];

	// Write address and data are caught separately; the answer waits for both.
	assign S_AXI_AWREADY = !aw_ff && !bv_ff;
	assign S_AXI_WREADY  = !w_ff && !bv_ff;
	assign S_AXI_ARREADY = !rv_ff;
	assign S_AXI_BVALID  = bv_ff;
	assign S_AXI_BRESP   = br_ff;
	assign S_AXI_RVALID  = rv_ff;
	assign S_AXI_RDATA   = rd_ff;
	assign S_AXI_RRESP   = rr_ff;
	wire [3:0]  widx = awa_ff[5:2];
	wire        wcfg = awa_ff[7:6] == 2'h0 && widx < 4'(N_CFG);
	wire        wro  = awa_ff[7:6] == 2'h0
		&& (widx == IDX_STAT0 || widx == IDX_STAT1);
	wire        do_wr = aw_ff && w_ff && !bv_ff;
	wire [31:0] wold = wcfg ? cfg_ff[widx] : 32'h0;
	wire [31:0] wmerge = {ws_ff[3] ? wd_ff[31:24] : wold[31:24],
		ws_ff[2] ? wd_ff[23:16] : wold[23:16],
		ws_ff[1] ? wd_ff[15:8] : wold[15:8],
		ws_ff[0] ? wd_ff[7:0] : wold[7:0]};
	wire [3:0]  ridx = S_AXI_ARADDR[5:2];
	wire        rmap = S_AXI_ARADDR[7:6] == 2'h0 && ridx <= IDX_STAT1;
	always_comb begin
		rsel = 32'h0;
		if (ridx < 4'(N_CFG))
			rsel = cfg_ff[ridx];
		else if (ridx == IDX_STAT0)
			rsel = {freq_ff, 9'h0, lock_ff, 1'b0, st_ff};
		else if (ridx == IDX_STAT1)
			rsel = {11'h0, dcb_ff, lvl_ff, 1'b0, volt_ff};
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			bv_ff <= 1'b0;
			rv_ff <= 1'b0;
			awa_ff <= 8'h0;
			wd_ff <= 32'h0;
			ws_ff <= 4'h0;
			br_ff <= RESP_OK;
			rr_ff <= RESP_OK;
			rd_ff <= 32'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_ff <= 1'b1;
				awa_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_ff <= 1'b1;
				wd_ff <= S_AXI_WDATA;
				ws_ff <= S_AXI_WSTRB;
			end
			if (do_wr) begin
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
				bv_ff <= 1'b1;
				br_ff <= (wcfg || wro) ? RESP_OK : RESP_ERR;
			end else if (bv_ff && S_AXI_BREADY)
				bv_ff <= 1'b0;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				rv_ff <= 1'b1;
				rd_ff <= rmap ? rsel : 32'h0;
				rr_ff <= rmap ? RESP_OK : RESP_ERR;
			end else if (rv_ff && S_AXI_RREADY)
				rv_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			for (int i = 0; i < N_CFG; i++)
				cfg_ff[i] <= rstv(i);
		end else if (do_wr && wcfg)
			cfg_ff[widx] <= clampw(widx, wmerge, {16'h0, maxf});
	end

	// Terminal FX with RX both on counts as stop.
	wire fx = fn_hit(tfn, TERM, FN_FX);
	wire rx = fn_hit(tfn, TERM, FN_RX);
	wire run_cmd = term_mode ? (fx ^ rx) : RUN_KEY;
	wire rev = term_mode ? rx : DIR_REV;
	wire hold = fn_hit(tfn, TERM, FN_HOLD);
	wire fall = fault_ff && !FAULT;
	wire restart_ok = fall && restart_en && term_mode && run_cmd;
	wire start = run_cmd && !FAULT && (!lock_ff || restart_ok);

	// The target is clamped again here because the limits may move later.
	wire [15:0] g0 = (tgt > maxf) ? maxf : tgt;
	wire [15:0] goal_eff = (g0 < stf) ? 16'h0 : g0;
	wire [15:0] goal = (st_ff == ST_RAMP && run_cmd) ? goal_eff : 16'h0;
	wire        up = goal > freq_ff;
	wire [15:0] rt = up ? tup : tdn;
	wire [23:0] den = 24'(rt) * 24'(TICKS_PER_RAMP_UNIT);
	wire [15:0] dfar = up ? goal - freq_ff : freq_ff - goal;
	wire [15:0] dorig = (freq_ff > orig_ff) ? freq_ff - orig_ff
		: orig_ff - freq_ff;
	wire [15:0] span = (goal > orig_ff) ? goal - orig_ff : orig_ff - goal;
	wire [23:0] span40 = (24'(maxf) * 24'd102) >> 8;
	// Short moves keep only the rounded start, so the end is cut off.
	wire        round_end = 24'(span) >= span40;
	wire [15:0] dnear = (round_end && dfar < dorig) ? dfar : dorig;
	wire [15:0] dsh = dnear >> SEG_SH;
	wire [3:0]  kf = (dsh >= 16'd7) ? 4'd8 : 4'(dsh + 16'd1);
	wire        s_on = up ? s_up : s_dn;
	wire [3:0]  k = s_on ? kf : 4'd8;
	wire [24:0] inc = (25'(maxf) * 25'(k)) >> 3;

	always_comb begin
		nxt_st = st_ff;
		nxt_freq = freq_ff;
		nxt_acc = acc_ff;
		nxt_tim = tim_ff;
		unique case (st_ff)
			ST_IDLE: begin
				nxt_freq = 16'h0;
				nxt_acc = 25'h0;
				if (start && sb_lvl != 8'h0 && sb_t != 16'h0) begin
					nxt_st = ST_SBRK;
					nxt_tim = 24'(sb_t) * 24'(TICKS_PER_BRK_UNIT);
				end else if (start)
					nxt_st = ST_RAMP;
			end
			ST_SBRK: begin
				if (!run_cmd)
					nxt_st = ST_IDLE;
				else if (tick && tim_ff <= 24'h1)
					nxt_st = ST_RAMP;
				else if (tick)
					nxt_tim = tim_ff - 24'h1;
			end
			ST_RAMP: begin
				if (freq_ff == goal)
					nxt_acc = 25'h0;
				else if (den == 24'h0)
					nxt_freq = goal;
				else if (hold)
					nxt_acc = acc_ff;
				else if (acc_ff >= 25'(den)) begin
					nxt_acc = acc_ff - 25'(den);
					nxt_freq = up ? freq_ff + 16'h1 : freq_ff - 16'h1;
				end else if (tick)
					nxt_acc = acc_ff + inc;
				if (!run_cmd && stop_m == STOP_COAST) begin
					nxt_st = ST_IDLE;
					nxt_freq = 16'h0;
				end else if (!run_cmd && stop_m == STOP_DCB
					&& freq_ff <= dbf && db_lvl != 8'h0
					&& db_t != 16'h0) begin
					nxt_st = ST_WAIT;
					nxt_freq = freq_ff;
					nxt_tim = 24'(db_w) * 24'(TICKS_PER_BRK_UNIT);
				end else if (!run_cmd && freq_ff == 16'h0)
					nxt_st = ST_IDLE;
			end
			ST_WAIT: begin
				if (tick && tim_ff <= 24'h1) begin
					nxt_st = ST_DCB;
					nxt_freq = 16'h0;
					nxt_tim = 24'(db_t) * 24'(TICKS_PER_BRK_UNIT);
				end else if (tick)
					nxt_tim = tim_ff - 24'h1;
			end
			ST_DCB: begin
				if (tick && tim_ff <= 24'h1)
					nxt_st = ST_IDLE;
				else if (tick)
					nxt_tim = tim_ff - 24'h1;
			end
			default: nxt_st = ST_IDLE;
		endcase
		if (FAULT) begin
			nxt_st = ST_IDLE;
			nxt_freq = 16'h0;
			nxt_acc = 25'h0;
		end
	end

	// Serial divider: ratio of frequency to base, 1024 meaning rated voltage.
	wire [16:0] rs = {rem_ff[15:0], quo_ff[25]};
	wire        ge = rs >= {1'b0, basef};
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt_ff <= 5'h0;
			rem_ff <= 17'h0;
			quo_ff <= 26'h0;
			r_ff <= 11'h0;
		end else if (cnt_ff == 5'h0) begin
			r_ff <= (quo_ff > 26'(V_UNITY)) ? V_UNITY : quo_ff[10:0];
			cnt_ff <= 5'd26;
			rem_ff <= 17'h0;
			quo_ff <= {freq_ff, 10'h0};
		end else begin
			cnt_ff <= cnt_ff - 5'h1;
			rem_ff <= ge ? rs - {1'b0, basef} : rs;
			quo_ff <= {quo_ff[24:0], ge};
		end
	end

	// A blend of r and r squared stands in for the 1.4 power curve.
	wire [31:0] rr = {21'h0, r_ff};
	wire [31:0] sq = (32'd154 * rr + ((32'd102 * rr * rr) >> 10)) >> 8;
	wire [31:0] vb = vf_sq ? sq : rr;
	wire [31:0] bman = rev ? {24'h0, bst[15:8]} : {24'h0, bst[7:0]};
	wire [31:0] bauto = lim({24'h0, bst[23:16]}, 32'h0, BOOST_HI);
	wire [31:0] bp = boost_auto ? bauto : bman;
	wire [31:0] bv = (bp * 32'd10 * (32'(V_UNITY) - rr)) >> 10;
	wire [31:0] vs = (vb + bv > 32'(V_UNITY)) ? 32'(V_UNITY) : vb + bv;
	wire [31:0] v1 = (vs * {24'h0, vsc} * 32'd10) >> 10;
	wire        v_on = (st_ff == ST_RAMP || st_ff == ST_WAIT)
		&& freq_ff >= stf;
	assign nxt_volt = v_on ? v1[10:0] : 11'h0;

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			st_ff <= ST_IDLE;
			freq_ff <= 16'h0;
			volt_ff <= 11'h0;
			acc_ff <= 25'h0;
			tim_ff <= 24'h0;
			orig_ff <= 16'h0;
			dcb_ff <= 1'b0;
			lvl_ff <= 8'h0;
			fault_ff <= 1'b0;
			lock_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			freq_ff <= nxt_freq;
			volt_ff <= (nxt_st == ST_IDLE) ? 11'h0 : nxt_volt;
			acc_ff <= nxt_acc;
			tim_ff <= nxt_tim;
			orig_ff <= (freq_ff == goal) ? freq_ff : orig_ff;
			dcb_ff <= nxt_st == ST_SBRK || nxt_st == ST_DCB;
			lvl_ff <= (nxt_st == ST_SBRK) ? sb_lvl
				: ((nxt_st == ST_DCB) ? db_lvl : 8'h0);
			fault_ff <= FAULT;
			lock_ff <= FAULT || (lock_ff && run_cmd && !restart_ok);
		end
	end

	assign DRIVE = '{freq_ff, volt_ff, dcb_ff, lvl_ff};
	assign RUNNING = st_ff != ST_IDLE;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	sequence s_stop_req(logic [1:0] m);
		st_ff == ST_RAMP && !run_cmd && !FAULT && stop_m == m;
	endsequence
	a_coast_cut: assert property (s_stop_req(STOP_COAST)
		|=> DRIVE.freq == 16'h0 && DRIVE.volt == 11'h0)
		else $error("coast stop did not cut output");
	a_dcb_enter: assert property (s_stop_req(STOP_DCB)
		##0 (freq_ff <= dbf && db_lvl != 8'h0 && db_t != 16'h0)
		|=> st_ff == ST_WAIT)
		else $error("brake wait not entered");
	a_dcb_skip: assert property (s_stop_req(STOP_DCB)
		##0 (db_lvl == 8'h0 || db_t == 16'h0) |=> st_ff != ST_WAIT)
		else $error("zero brake setting still braked");
	a_wait_brake: assert property (st_ff == ST_WAIT && tick
		&& tim_ff <= 24'h1 && !FAULT
		|=> st_ff == ST_DCB && DRIVE.dcb_on ##1 DRIVE.dcb_on)
		else $error("brake not applied after wait");
	a_sbrk_skip: assert property (st_ff == ST_IDLE && start
		&& (sb_lvl == 8'h0 || sb_t == 16'h0) |=> st_ff == ST_RAMP)
		else $error("start brake not skipped");
	a_hold_freeze: assert property (st_ff == ST_RAMP && hold
		&& run_cmd && !FAULT && den != 24'h0 |=> $stable(freq_ff))
		else $error("ramp moved while held");
	a_volt_start: assert property (DRIVE.volt != 11'h0
		|-> $past(freq_ff) >= $past(stf))
		else $error("voltage below start frequency");
	a_goal_limit: assert property (goal_eff <= maxf
		&& (goal_eff == 16'h0 || goal_eff >= stf))
		else $error("target outside frequency limits");
	a_fault_restart: assert property (restart_ok
		|=> st_ff != ST_IDLE)
		else $error("no restart after fault clear");
	a_key_norestart: assert property (fall && !term_mode
		|=> st_ff == ST_IDLE [*2])
		else $error("key mode restarted after fault");
	a_reset_clear: assert property (@(posedge CLK) disable iff (1'b0)
		!RESETN |=> DRIVE.freq == 16'h0 && st_ff == ST_IDLE)
		else $error("reset did not clear output");
endmodule : mrs_sequencer

/* test/mrs_term_model.sv */
// Terminal and fault switch model at the input side of the sequencer.
`timescale 1ns/1ps
module mrs_term_model (
	input  wire logic       clk,
	input  wire logic       run_cmd,
	input  wire logic       hold_cmd,
	input  wire logic       fault_cmd,
	output logic      [4:0] term,
	output logic            fault
);
	// Levels change only after a clock edge, as a synchronised input would.
	always @(posedge clk) begin
		term <= {2'h0, hold_cmd, 1'h0, run_cmd};
		fault <= fault_cmd;
	end
	initial begin
		term = 5'h00;
		fault = 1'h0;
	end
endmodule : mrs_term_model

/* test/motor_ramp_stop_sequencer_tb.sv */
// Self-checking bench for the ramp and stop sequencer.
`timescale 1ns/1ps
module motor_ramp_stop_sequencer_tb;
	import mrs_pkg::*;
	localparam int TK = 50;
	logic        clk = 1'b0, rstn = 1'b0, seen_dcb = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic  [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic        run_key = 1'b0, run_cmd = 1'b0, hold_cmd = 1'b0;
	logic        flt_cmd = 1'b0, dir_rev = 1'b0;
	logic        awr, wrr, bv, arr, rv, flt, running;
	logic  [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic  [4:0] term;
	mrs_drive_t  drv;
	logic [15:0] tgt;
	int          n_mismatch = 0, cmp_count = 0, cyc = 0;
	always #10 clk = ~clk;
	mrs_term_model i_term (.clk(clk), .run_cmd(run_cmd), .hold_cmd(hold_cmd),
		.fault_cmd(flt_cmd), .term(term), .fault(flt));
	mrs_sequencer #(.TICK_CYCLES(TK)) i_dut (.CLK(clk), .RESETN(rstn),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
		.S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .RUN_KEY(run_key),
		.TERM(term), .DIR_REV(dir_rev), .FAULT(flt), .DRIVE(drv),
		.RUNNING(running));
	always @(posedge clk) begin
		cyc++;
		if (drv.dcb_on === 1'b1)
			seen_dcb <= 1'b1;
		if (cyc == 95000) begin
			fail("timeout");
			results();
		end
	end
	task automatic results();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic fail(input string m);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : fail
	task automatic chk(input logic [31:0] g, input logic [31:0] e, string m);
		cmp_count++;
		if (g !== e)
			fail($sformatf("%s got %h exp %h", m, g, e));
	endtask : chk
	task automatic chk_rng(input int g, input int lo, input int hi, string m);
		cmp_count++;
		if (g < lo || g > hi)
			fail($sformatf("%s got %0d exp %0d..%0d", m, g, lo, hi));
	endtask : chk_rng
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wrr)
				wv <= 1'b0;
		end while (!(bry && bv));
		r = bresp;
		bry <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
		end while (!(rry && rv));
		d = rdata;
		r = rresp;
		rry <= 1'b0;
	endtask : rd
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk(32'(r), 32'(RESP_OK), "write response");
	endtask : wreg
	function automatic logic hit(input int sel, input logic [15:0] v);
		case (sel)
		0: return drv.freq === v;
		1: return drv.dcb_on === v[0];
		default: return running === v[0];
		endcase
	endfunction : hit
	// Counts settled cycles until the chosen drive field or RUNNING shows v.
	task automatic wait_for(input int sel, input logic [15:0] v, output int n);
		n = 0;
		while (!hit(sel, v) && n < 30000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 30000)
			fail("wait expired");
	endtask : wait_for
	// A ramp time of 2 covers zero to the 60 Hz maximum in 200 ticks.
	// The ramp moves at most one step per clock, so with short sim ticks
	// a ramp time of 1 would be rate limited and run slow.
	function automatic int ramp_cyc(input int f);
		return f * TK * 200 / 6000;
	endfunction : ramp_cyc
	task automatic set_run(input logic v);
		@(posedge clk);
		run_cmd <= v;
	endtask : set_run
	task automatic coast();
		set_run(1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk({drv.freq, drv.volt, 4'h0, running}, 32'h0, "coast");
	endtask : coast
	initial begin
		logic [31:0] d;
		logic  [1:0] r;
		int          n, vs;
		logic [31:0] rv_t [13] = '{RST_CTRL, RST_TGT, RST_TUP, RST_TDN,
			RST_MAXF, RST_BASEF, RST_STF, RST_VSC, RST_BOOST, RST_SBRK,
			RST_DBRK, RST_DBF, RST_TFN};
		logic  [7:0] ca [6] = '{8'h1c, 8'h1c, 8'h18, 8'h10, 8'h14, 8'h08};
		logic [31:0] cw [6] = '{32'd200, 32'd5, 32'd0, 32'd30000, 32'd9, 32'd0};
		logic [31:0] ce [6] = '{VSC_HI, VSC_LO, STF_LO, FREQ_HI, BASE_LO, 32'd0};
		void'($urandom(32'h6e8b9092));
		tgt = 16'(600 * $urandom_range(5, 2));
		cw[5] = $urandom_range(60000);
		ce[5] = cw[5];
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < N_CFG; i++) begin
			rd(8'(4 * i), d, r);
			chk(d, rv_t[i], "reset value");
		end
		chk(32'(drv.freq), 32'h0, "freq after reset");
		chk(32'({drv.volt, drv.dcb_on, drv.dcb_lvl}), 32'h0, "drive");
		chk(32'(running), 32'h0, "running after reset");
		rd(8'h3c, d, r);
		chk(d, 32'h0, "unmapped read data");
		chk(32'(r), 32'(RESP_ERR), "unmapped read");
		wr(8'h40, 32'h1, r);
		chk(32'(r), 32'(RESP_ERR), "unmapped write");
		for (int i = 0; i < 6; i++) begin
			wreg(ca[i], cw[i]);
			rd(ca[i], d, r);
			chk(d, ce[i], "clamped setting");
		end
		$display("test registers done");
		wreg(8'h10, 32'd6000);
		wreg(8'h14, 32'd6000);
		wreg(8'h18, 32'd50);
		wreg(8'h1c, 32'd100);
		wreg(8'h08, 32'd2);
		wreg(8'h0c, 32'd2);
		wreg(8'h20, 32'h0);
		wreg(8'h30, 32'h20 | (32'd23 << 10) | (32'd2 << 15) | (32'd3 << 20));
		wreg(8'h04, 32'(tgt));
		wreg(8'h00, 32'h09);
		seen_dcb = 1'b0;
		set_run(1'b1);
		wait_for(0, tgt, n);
		chk_rng(n, ramp_cyc(tgt) - 100, ramp_cyc(tgt) + 100, "linear up");
		chk(32'(seen_dcb), 32'h0, "no start brake");
		coast();
		wreg(8'h00, 32'h19);
		set_run(1'b1);
		wait_for(0, tgt, vs);
		chk_rng(vs, n + 20, 30000, "s-shape longer");
		coast();
		$display("test ramp shapes done");
		vs = $urandom_range(110, 40);
		wreg(8'h1c, 32'(vs));
		wreg(8'h04, 32'd6000);
		wreg(8'h00, 32'h09);
		set_run(1'b1);
		wait_for(0, 16'd6000, n);
		repeat (40) @(posedge clk);
		#1;
		chk_rng(int'(drv.volt), vs * 10 - 2, vs * 10 + 2, "volt at base");
		coast();
		wreg(8'h1c, 32'd100);
		wreg(8'h20, 32'h00080a05);
		wreg(8'h04, 32'd3000);
		wreg(8'h00, 32'h08);
		@(posedge clk);
		dir_rev <= 1'b1;
		run_key <= 1'b1;
		wait_for(0, 16'd3000, n);
		repeat (40) @(posedge clk);
		#1;
		chk_rng(int'(drv.volt), 540, 560, "reverse boost");
		wreg(8'h00, 32'hc8);
		repeat (5) @(posedge clk);
		#1;
		chk_rng(int'(drv.volt), 400, 470, "square curve");
		@(posedge clk);
		run_key <= 1'b0;
		dir_rev <= 1'b0;
		wreg(8'h04, 32'(tgt));
		wreg(8'h00, 32'h01);
		set_run(1'b1);
		wait_for(0, tgt / 2, n);
		@(posedge clk);
		hold_cmd <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		d = 32'(drv.freq);
		repeat (300) @(posedge clk);
		#1;
		chk(32'(drv.freq), d, "ramp held");
		@(posedge clk);
		hold_cmd <= 1'b0;
		wait_for(0, tgt, n);
		set_run(1'b0);
		wait_for(0, 16'd0, n);
		chk_rng(n, ramp_cyc(tgt) - 100, ramp_cyc(tgt) + 100, "ramp down");
		wait_for(2, 16'd0, n);
		chk_rng(n, 0, 5, "stopped");
		$display("test hold and stop done");
		wreg(8'h28, 32'h232);
		wreg(8'h2c, 32'h000101f4);
		wreg(8'h00, 32'h05);
		set_run(1'b1);
		wait_for(0, tgt, n);
		set_run(1'b0);
		wait_for(0, 16'd500, n);
		wait_for(1, 16'd1, n);
		chk_rng(n, 420, 580, "brake wait");
		chk({drv.freq, drv.dcb_lvl}, {16'h0, 8'd50}, "brake level");
		wait_for(1, 16'd0, n);
		chk_rng(n, 920, 1080, "brake time");
		wait_for(2, 16'd0, n);
		chk_rng(n, 0, 5, "idle after brake");
		wreg(8'h28, 32'h200);
		wreg(8'h00, 32'h25);
		set_run(1'b1);
		wait_for(0, tgt, n);
		seen_dcb = 1'b0;
		set_run(1'b0);
		wait_for(2, 16'd0, n);
		chk_rng(n, ramp_cyc(tgt) + 20, 30000, "s-shape down longer");
		chk(32'(seen_dcb), 32'h0, "brake skipped");
		$display("test stop brake done");
		wreg(8'h24, 32'h128);
		wreg(8'h00, 32'h09);
		set_run(1'b1);
		wait_for(1, 16'd1, n);
		chk({drv.freq, drv.dcb_lvl}, {16'h0, 8'd40}, "start brake");
		wait_for(1, 16'd0, n);
		chk_rng(n, 420, 580, "start brake time");
		wait_for(0, tgt, n);
		coast();
		wreg(8'h24, 32'h0);
		wreg(8'h00, 32'h0b);
		set_run(1'b1);
		wait_for(0, tgt, n);
		@(posedge clk);
		flt_cmd <= 1'b1;
		wait_for(2, 16'd0, n);
		@(posedge clk);
		flt_cmd <= 1'b0;
		wait_for(2, 16'd1, n);
		chk_rng(n, 0, 10, "restart after clear");
		coast();
		wreg(8'h00, 32'h0a);
		@(posedge clk);
		run_key <= 1'b1;
		wait_for(0, tgt, n);
		@(posedge clk);
		flt_cmd <= 1'b1;
		wait_for(2, 16'd0, n);
		@(posedge clk);
		flt_cmd <= 1'b0;
		repeat (500) @(posedge clk);
		#1;
		chk(32'(running), 32'h0, "no key restart");
		@(posedge clk);
		run_key <= 1'b0;
		$display("test fault restart done");
		results();
	end
endmodule : motor_ramp_stop_sequencer_tb
